// >>> dv/fi_link_model.sv
// Receiving end of the link under test: keeps the last beat that arrived
`timescale 1ns/1ps
`default_nettype none
module fi_link_model (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Line from the injector
  input  wire fi_pkg::fi_beat_t beat,
  input  wire logic             valid,
  input  wire logic             er,
  // Captured view
  output fi_pkg::fi_beat_t      rx_beat,
  output logic                  rx_er
);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_beat <= '0;
      rx_er   <= 1'b0;
    end else if (valid) begin
      rx_beat <= beat;
      rx_er   <= er;
    end
  end
endmodule // fi_link_model
`default_nettype wire

// >>> dv/test_ethernet_fault_injector.sv
// Self-checking bench of the fault injector
`include "fi_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module test_ethernet_fault_injector;
  logic clk, rst, awv, wv, bry, arv, rry, inv;
  logic awr, wr_, bv, arr, rv, ov, ter, alm, rer;
  logic [7:0] awa, ara;
  logic [31:0] wd, rdt;
  logic [1:0] br, rr;
  fi_pkg::fi_beat_t ib, ob, rb;
  int n_fail, checks_done;

  fi_top #(.SEC_CYC(20), .SEC10_CYC(200), .NUM_LANES(20)) uut (
    .clk(clk), .rst(rst), .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr_),
    .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ara),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdt), .s_axi_rresp(rr),
    .s_axi_rvalid(rv), .s_axi_rready(rry), .in_beat(ib), .in_valid(inv),
    .out_beat(ob), .out_valid(ov), .tx_er(ter), .alarm_active(alm));
  fi_link_model far (.clk(clk), .rst(rst), .beat(ob), .valid(ov), .er(ter),
    .rx_beat(rb), .rx_er(rer));

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ad, dd;
    ad = 0;
    dd = 0;
    @(posedge clk);
    awa <= a; awv <= 1; wd <= d; wv <= 1; bry <= 1;
    while (!(ad && dd)) begin
      @(posedge clk);
      if (awv && awr) begin ad = 1; awv <= 0; end
      if (wv && wr_) begin dd = 1; wv <= 0; end
    end
    do @(posedge clk); while (bv !== 1'b1);
    bry <= 0;
    chk("bresp", br, er);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    @(posedge clk);
    ara <= a; arv <= 1; rry <= 1;
    do @(posedge clk); while (arr !== 1'b1);
    arv <= 0;
    do @(posedge clk); while (rv !== 1'b1);
    rry <= 0;
    chk("rresp", rr, er);
    chk("rdata", rdt, exp);
  endtask

  // One beat out, then look at what the far end got
  task automatic snd(input fi_pkg::fi_kind_t k, input logic [4:0] l, input logic [63:0] exp);
    @(posedge clk);
    ib <= '{data: 64'h0123_4567_89ab_cdef, sync: 2'b01, kind: k, lane: l, sof: 1'b1};
    inv <= 1;
    @(posedge clk);
    inv <= 0;
    @(posedge clk);
    #1;
    chk("data", rb.data, exp);
  endtask

  localparam logic [63:0] D = 64'h0123_4567_89ab_cdef;

  task automatic s_reset();
    rd(`FI_CTRL_OFS, 32'h0000_2000, 2'b00);
    rd(`FI_GROUP_OFS, 32'h1, 2'b00);
    rd(`FI_LANE_OFS, 32'h000f_ffff, 2'b00);
    rd(8'h1c, 32'h0, 2'b10);
    wr(8'h1c, 32'h5, 2'b10);
  endtask

  task automatic s_off();
    wr(`FI_CTRL_OFS, 32'h0000_0010, 2'b00);
    wr(`FI_TRIG_OFS, 32'h1, 2'b00);
    snd(fi_pkg::FI_K_FCS, 5'h0, D);
  endtask

  task automatic s_manual();
    wr(`FI_CTRL_OFS, 32'h0000_0211, 2'b00);
    wr(`FI_GROUP_OFS, 32'h2, 2'b00);
    wr(`FI_TRIG_OFS, 32'h1, 2'b00);
    repeat (2) snd(fi_pkg::FI_K_FCS, 5'h0, D ^ 64'hffff_ffff);
    snd(fi_pkg::FI_K_FCS, 5'h0, D);
    rd(`FI_STAT_OFS, 32'h0, 2'b00);
  endtask

  task automatic s_cv1g();
    wr(`FI_CTRL_OFS, 32'h0000_0081, 2'b00);
    wr(`FI_GROUP_OFS, 32'h1, 2'b00);
    wr(`FI_TRIG_OFS, 32'h1, 2'b00);
    snd(fi_pkg::FI_K_DATA, 5'h0, D);
    chk("tx_er", rer, 1'b1);
    snd(fi_pkg::FI_K_DATA, 5'h0, D);
    chk("tx_er", rer, 1'b0);
  endtask

  task automatic s_pcs();
    wr(`FI_CTRL_OFS, 32'h0000_02a5, 2'b00);
    wr(`FI_LANE_OFS, 32'h2, 2'b00);
    wr(`FI_GROUP_OFS, 32'h2, 2'b00);
    wr(`FI_TRIG_OFS, 32'h1, 2'b00);
    snd(fi_pkg::FI_K_CTRL, 5'h0, D);
    repeat (2) snd(fi_pkg::FI_K_CTRL, 5'h1, {D[63:8], 8'h00});
    snd(fi_pkg::FI_K_CTRL, 5'h1, D);
  endtask

  task automatic s_all_alarm();
    wr(`FI_CTRL_OFS, 32'h0000_0217, 2'b00);
    repeat (2) snd(fi_pkg::FI_K_FCS, 5'h0, D ^ 64'hffff_ffff);
    wr(`FI_CTRL_OFS, 32'h0000_0100, 2'b00);
    repeat (2) @(posedge clk);
    chk("alarm", alm, 1'b1);
    rd(`FI_STAT_OFS, 32'h0002_0000, 2'b00);
    rd(`FI_CNT_OFS, 32'h7, 2'b00);
  endtask

  // Group lands every 20 and every 200 cycles with the bench's timer spans
  task automatic s_periodic();
    wr(`FI_GROUP_OFS, 32'h1, 2'b00);
    wr(`FI_CTRL_OFS, 32'h0000_0012, 2'b00);
    repeat (100) @(posedge clk);
    rd(`FI_STAT_OFS, 32'h0001_0005, 2'b00);
    wr(`FI_CTRL_OFS, 32'h0000_0010, 2'b00);
    wr(`FI_CTRL_OFS, 32'h0000_0013, 2'b00);
    repeat (200) @(posedge clk);
    rd(`FI_STAT_OFS, 32'h0001_0001, 2'b00);
    wr(`FI_CTRL_OFS, 32'h0000_0010, 2'b00);
  endtask

  // Exponent 2: one group after the hundredth beat, trigger ignored
  task automatic s_ratio();
    wr(`FI_CTRL_OFS, 32'h0000_2014, 2'b00);
    repeat (99) snd(fi_pkg::FI_K_IDLE, 5'h0, D);
    wr(`FI_TRIG_OFS, 32'h1, 2'b00);
    rd(`FI_STAT_OFS, 32'h0, 2'b00);
    snd(fi_pkg::FI_K_IDLE, 5'h0, D);
    rd(`FI_STAT_OFS, 32'h0001_0001, 2'b00);
    snd(fi_pkg::FI_K_FCS, 5'h0, D ^ 64'hffff_ffff);
  endtask

  task automatic s_alt();
    wr(`FI_ALT_OFS, 32'h3, 2'b00);
    wr(`FI_CTRL_OFS, 32'h0000_0016, 2'b00);
    repeat (3) snd(fi_pkg::FI_K_FCS, 5'h0, D);
    snd(fi_pkg::FI_K_FCS, 5'h0, D ^ 64'hffff_ffff);
    repeat (2) snd(fi_pkg::FI_K_FCS, 5'h0, D);
  endtask

  // Gap beat vanishes from the line, the frame beat behind it stays
  task automatic s_gap();
    wr(`FI_CTRL_OFS, 32'h0000_0007, 2'b00);
    @(posedge clk);
    ib.kind <= fi_pkg::FI_K_IDLE;
    inv <= 1;
    @(posedge clk);
    ib.kind <= fi_pkg::FI_K_FCS;
    #1;
    chk("out_valid", ov, 1'b0);
    @(posedge clk);
    inv <= 0;
    #1;
    chk("out_valid", ov, 1'b1);
  endtask

  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end

  initial begin
    n_fail = 0; checks_done = 0;
    rst = 1; awv = 0; wv = 0; bry = 0; arv = 0; rry = 0; inv = 0;
    awa = '0; ara = '0; wd = '0; ib = '0;
    repeat (10) @(posedge clk);
    rst <= 0;
    s_reset();
    s_off();
    s_manual();
    s_cv1g();
    s_pcs();
    s_all_alarm();
    s_periodic();
    s_ratio();
    s_alt();
    s_gap();
    conclude();
  end

  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    conclude();
  end
endmodule // test_ethernet_fault_injector
`default_nettype wire

// >>> hdl/fi_defines.svh
// Register offsets, field positions, reset values and timing of the injector
`ifndef FI_DEFINES_SVH
`define FI_DEFINES_SVH
`define FI_CTRL_OFS 8'h00
`define FI_GROUP_OFS 8'h04
`define FI_ALT_OFS 8'h08
`define FI_LANE_OFS 8'h0c
`define FI_TRIG_OFS 8'h10
`define FI_STAT_OFS 8'h14
`define FI_CNT_OFS 8'h18
`define FI_MODE_LSB 0
`define FI_DEST_LSB 4
`define FI_ALARM_BIT 8
`define FI_SPD_LSB 9
`define FI_FEC_BIT 11
`define FI_EXP_LSB 12
`define FI_CTRL_MASK 32'h0000_7ff7
`define FI_CTRL_RST 32'h0000_2000
`define FI_GROUP_RST 16'h0001
`define FI_ALT_RST 16'h0001
`define FI_LANE_RST 32'hffff_ffff
`define FI_SEC_MS 1000
`define FI_SEC10_MS 10000
`define FI_CLK_KHZ 100000
`define FI_MS_CYC(ms) ((ms) * `FI_CLK_KHZ)
`define FI_RESP_OK 2'b00
`define FI_RESP_ERR 2'b10
`endif

// >>> hdl/fi_pkg.sv
// Types shared by the fault injector modules
package fi_pkg;
  typedef enum logic [2:0] {
    FI_OFF = 3'h0, FI_MANUAL = 3'h1, FI_SEC1 = 3'h2, FI_SEC10 = 3'h3,
    FI_RATIO = 3'h4, FI_BURST = 3'h5, FI_ALT = 3'h6, FI_ALL = 3'h7
  } fi_mode_t;
  typedef enum logic [3:0] {
    FI_D_IFG = 4'h0, FI_D_FCS = 4'h1, FI_D_PRE = 4'h2, FI_D_IPCS = 4'h3,
    FI_D_FRAG = 4'h4, FI_D_L4CS = 4'h5, FI_D_PAT = 4'h6, FI_D_SEQ = 4'h7,
    FI_D_CV = 4'h8, FI_D_FEC = 4'h9, FI_D_BTYPE = 4'ha, FI_D_SYNC = 4'hb,
    FI_D_AM = 4'hc, FI_D_BIP = 4'hd
  } fi_dest_t;
  typedef enum logic [3:0] {
    FI_K_IDLE = 4'h0, FI_K_PRE = 4'h1, FI_K_DATA = 4'h2, FI_K_FCS = 4'h3,
    FI_K_IPCS = 4'h4, FI_K_IPFLG = 4'h5, FI_K_L4CS = 4'h6, FI_K_PAT = 4'h7,
    FI_K_SEQ = 4'h8, FI_K_CTRL = 4'h9, FI_K_AM = 4'ha, FI_K_FEC = 4'hb
  } fi_kind_t;
  typedef enum logic [1:0] {
    FI_1G = 2'h0, FI_10G = 2'h1, FI_25G = 2'h2, FI_100G = 2'h3
  } fi_speed_t;
  typedef struct packed {
    logic [63:0] data;
    logic [1:0]  sync;
    fi_kind_t    kind;
    logic [4:0]  lane;
    logic        sof;
  } fi_beat_t;
  typedef struct packed {
    fi_mode_t   mode;
    fi_dest_t   dest;
    logic       alarm;
    fi_speed_t  speed;
    logic       fec;
    logic [2:0] exp_n;
  } fi_cfg_t;
  typedef enum logic [1:0] {FI_BUS_IDLE = 2'b01, FI_BUS_RESP = 2'b10} fi_bus_t;
endpackage

// >>> hdl/fi_sched.sv
// Insertion scheduler: turns mode events into a count of pending errors
`timescale 1ns/1ps
`default_nettype none
module fi_sched #(
  parameter int unsigned SEC_CYC   = 100,
  parameter int unsigned SEC10_CYC = 1000
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Configuration
  input  wire fi_pkg::fi_mode_t mode,
  input  wire logic [2:0]       exp_n,
  input  wire logic [15:0]      group,
  input  wire logic [15:0]      alt_n,
  // Events
  input  wire logic             trig,
  input  wire logic             blk,
  input  wire logic             frm,
  input  wire logic             used,
  // Schedule
  output logic [16:0]           pend,
  output logic                  armed
);
  logic [31:0] tmr;
  logic [31:0] blk_cnt;
  logic [15:0] frm_cnt;
  logic [31:0] tlim;
  logic        fire;

  function automatic logic [31:0] pow10(input logic [2:0] n);
    pow10 = 32'h1;
    for (int i = 0; i < 7; i++)
      if (i < 32'(n)) pow10 = pow10 * 32'd10;
  endfunction

  assign tlim = (mode == fi_pkg::FI_SEC10) ? 32'(SEC10_CYC - 1) : 32'(SEC_CYC - 1);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) tmr <= 32'h0;
    else if ((mode != fi_pkg::FI_SEC1 && mode != fi_pkg::FI_SEC10) || tmr >= tlim) tmr <= 32'h0;
    else tmr <= tmr + 32'h1;
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) blk_cnt <= 32'h0;
    else if (mode != fi_pkg::FI_RATIO) blk_cnt <= 32'h0;
    else if (blk) blk_cnt <= (blk_cnt >= pow10(exp_n) - 32'h1) ? 32'h0 : blk_cnt + 32'h1;
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) frm_cnt <= 16'h0;
    else if (mode != fi_pkg::FI_ALT) frm_cnt <= 16'h0;
    else if (frm) frm_cnt <= (frm_cnt + 16'h1 >= alt_n) ? 16'h0 : frm_cnt + 16'h1;
  end

  always_comb begin
    case (mode)
      fi_pkg::FI_MANUAL, fi_pkg::FI_BURST: fire = trig;
      fi_pkg::FI_SEC1, fi_pkg::FI_SEC10: fire = (tmr >= tlim);
      fi_pkg::FI_RATIO: fire = blk && (blk_cnt >= pow10(exp_n) - 32'h1);
      fi_pkg::FI_ALT: fire = frm && (frm_cnt + 16'h1 >= alt_n);
      default: fire = 1'b0;
    endcase
  end

  // A new group and a used error in one cycle both count
  always_ff @(posedge clk or posedge rst) begin
    if (rst) pend <= 17'h0;
    else if (mode == fi_pkg::FI_OFF || mode == fi_pkg::FI_ALL) pend <= 17'h0;
    else pend <= pend - {16'h0, used} + (fire ? {1'b0, group} : 17'h0);
  end
  assign armed = (pend != 17'h0) || (mode == fi_pkg::FI_ALL);
endmodule // fi_sched
`default_nettype wire

// >>> hdl/fi_top.sv
// Ethernet transmit fault injector with AXI4-Lite control
// How it works
// - Mode off passes all traffic unchanged and inserts nothing.
// - Manual: each trigger inserts one group of errors, then stops.
// - Per-second burst: one group of errors every second.
// - Per-ten-second burst: one group of errors every ten seconds.
// - Ratio: one group per ten-to-the-n blocks, n below 2 taken as 2; trigger only shows status.
// - Selected alarm is held active for as long as it is selected.
// - Gap fault sends a frame behind a shortened inter-frame gap.
// - Frame check fault sends a frame with a wrong FCS.
// - Preamble fault alters the preamble, only at 10 Gbps or below.
// - IP checksum fault sends a wrong IPv4 header checksum.
// - Fragmentation fault sends IPv4 data marked as fragmented.
// - Transport checksum fault sends a wrong TCP or UDP checksum.
// - Test pattern fault flips payload pattern bits.
// - Sequence fault corrupts the pattern sequence number.
// - Coding violation: bad 64-bit block at 10G, TX_ER at 1G or below.
// - FEC symbol fault only with FEC on, for 25G and 100G.
// - PCS burst inserts exactly the configured count, then stops.
// - PCS rate inserts continuously at the ratio until mode changes.
// - PCS alternate repeats insertion once per configured frame count.
// - PCS all corrupts every transmitted frame.
// - PCS faults go only into lanes set in fault_lane_select.
// - PCS faults: bad block type, bad sync header, bad marker, bad BIP.
//
// Implementation choices: the placing of the registers and the AXI4-Lite slave port.
`include "fi_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module fi_top #(
  parameter int unsigned SEC_CYC   = `FI_MS_CYC(`FI_SEC_MS),
  parameter int unsigned SEC10_CYC = `FI_MS_CYC(`FI_SEC10_MS),
  parameter int unsigned NUM_LANES = 20
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // AXI4-Lite write
  input  wire logic [7:0]       s_axi_awaddr,
  input  wire logic             s_axi_awvalid,
  output logic                  s_axi_awready,
  input  wire logic [31:0]      s_axi_wdata,
  input  wire logic [3:0]       s_axi_wstrb,
  input  wire logic             s_axi_wvalid,
  output logic                  s_axi_wready,
  output logic [1:0]            s_axi_bresp,
  output logic                  s_axi_bvalid,
  input  wire logic             s_axi_bready,
  // AXI4-Lite read
  input  wire logic [7:0]       s_axi_araddr,
  input  wire logic             s_axi_arvalid,
  output logic                  s_axi_arready,
  output logic [31:0]           s_axi_rdata,
  output logic [1:0]            s_axi_rresp,
  output logic                  s_axi_rvalid,
  input  wire logic             s_axi_rready,
  // Transmit stream in
  input  wire fi_pkg::fi_beat_t in_beat,
  input  wire logic             in_valid,
  // Transmit stream out
  output fi_pkg::fi_beat_t      out_beat,
  output logic                  out_valid,
  output logic                  tx_er,
  output logic                  alarm_active
);

  logic [31:0]      ctrl;
  logic [15:0]      group;
  logic [15:0]      alt_n;
  logic [31:0]      lane_sel;
  logic [31:0]      ins_cnt;
  logic             trig;
  fi_pkg::fi_cfg_t  cfg;
  logic [2:0]       exp_n;
  logic [16:0]      pend;
  logic             armed;
  fi_pkg::fi_beat_t nb;
  logic             hit;
  logic             drop;
  logic             er;
  logic             lane_ok;

  function automatic logic [31:0] merge(
    input logic [31:0] old,
    input logic [31:0] wd,
    input logic [3:0]  st
  );
    for (int i = 0; i < 4; i++)
      merge[8*i +: 8] = st[i] ? wd[8*i +: 8] : old[8*i +: 8];
  endfunction

  function automatic logic known(input logic [7:0] a);
    known = (a == `FI_CTRL_OFS) || (a == `FI_GROUP_OFS) || (a == `FI_ALT_OFS)
         || (a == `FI_LANE_OFS) || (a == `FI_TRIG_OFS) || (a == `FI_STAT_OFS)
         || (a == `FI_CNT_OFS);
  endfunction

  // Write channel capture

  fi_pkg::fi_bus_t wst;
  logic            aw_have;
  logic            w_have;
  logic [7:0]      aw_addr;
  logic [31:0]     w_data;
  logic [3:0]      w_strb;
  logic            aw_take;
  logic            w_take;
  logic            commit;
  logic            next_aw_have;
  logic            next_w_have;

  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take  = s_axi_wvalid && s_axi_wready;
  assign commit  = aw_have && w_have && (wst == fi_pkg::FI_BUS_IDLE);
  assign next_aw_have = aw_take || (aw_have && !commit);
  assign next_w_have  = w_take || (w_have && !commit);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      aw_have       <= 1'b0;
      aw_addr       <= 8'h00;
      s_axi_awready <= 1'b0;
    end else begin
      aw_have       <= next_aw_have;
      s_axi_awready <= !next_aw_have;
      if (aw_take) aw_addr <= s_axi_awaddr;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      w_have       <= 1'b0;
      w_data       <= 32'h0;
      w_strb       <= 4'h0;
      s_axi_wready <= 1'b0;
    end else begin
      w_have       <= next_w_have;
      s_axi_wready <= !next_w_have;
      if (w_take) begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wst          <= fi_pkg::FI_BUS_IDLE;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `FI_RESP_OK;
    end else begin
      case (wst)
        fi_pkg::FI_BUS_IDLE: begin
          if (commit) begin
            wst          <= fi_pkg::FI_BUS_RESP;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= known(aw_addr) ? `FI_RESP_OK : `FI_RESP_ERR;
          end
        end
        fi_pkg::FI_BUS_RESP: begin
          if (s_axi_bready) begin
            wst          <= fi_pkg::FI_BUS_IDLE;
            s_axi_bvalid <= 1'b0;
          end
        end
        default: begin
          wst          <= fi_pkg::FI_BUS_IDLE;
          s_axi_bvalid <= 1'b0;
        end
      endcase
    end
  end

  // Configuration registers

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl     <= `FI_CTRL_RST;
      group    <= `FI_GROUP_RST;
      alt_n    <= `FI_ALT_RST;
      lane_sel <= `FI_LANE_RST & 32'((64'h1 << NUM_LANES) - 64'h1);
    end else if (commit) begin
      case (aw_addr)
        `FI_CTRL_OFS: ctrl <= merge(ctrl, w_data, w_strb) & `FI_CTRL_MASK;
        `FI_GROUP_OFS: group <= 16'(merge({16'h0, group}, w_data, w_strb));
        `FI_ALT_OFS: alt_n <= 16'(merge({16'h0, alt_n}, w_data, w_strb));
        `FI_LANE_OFS: lane_sel <= merge(lane_sel, w_data, w_strb)
                                  & 32'((64'h1 << NUM_LANES) - 64'h1);
        default: ;
      endcase
    end
  end

  // Trigger strobe; in ratio mode the scheduler ignores it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) trig <= 1'b0;
    else trig <= commit && aw_addr == `FI_TRIG_OFS && w_strb[0] && w_data[0];
  end

  always_comb begin
    cfg.mode  = fi_pkg::fi_mode_t'(ctrl[`FI_MODE_LSB +: 3]);
    cfg.dest  = fi_pkg::fi_dest_t'(ctrl[`FI_DEST_LSB +: 4]);
    cfg.alarm = ctrl[`FI_ALARM_BIT];
    cfg.speed = fi_pkg::fi_speed_t'(ctrl[`FI_SPD_LSB +: 2]);
    cfg.fec   = ctrl[`FI_FEC_BIT];
    cfg.exp_n = ctrl[`FI_EXP_LSB +: 3];
    exp_n     = (cfg.exp_n < 3'd2) ? 3'd2 : cfg.exp_n;
  end

  // Read channel

  fi_pkg::fi_bus_t rst_st;
  logic [31:0]     rd_mux;
  logic            ar_take;

  assign ar_take = s_axi_arvalid && s_axi_arready;

  always_comb begin
    case (s_axi_araddr)
      `FI_CTRL_OFS: rd_mux = ctrl;
      `FI_GROUP_OFS: rd_mux = {16'h0, group};
      `FI_ALT_OFS: rd_mux = {16'h0, alt_n};
      `FI_LANE_OFS: rd_mux = lane_sel;
      `FI_STAT_OFS: rd_mux = {14'h0, alarm_active, armed, pend[15:0]};
      `FI_CNT_OFS: rd_mux = ins_cnt;
      default: rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rst_st        <= fi_pkg::FI_BUS_IDLE;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= `FI_RESP_OK;
    end else begin
      case (rst_st)
        fi_pkg::FI_BUS_IDLE: begin
          s_axi_arready <= !ar_take;
          if (ar_take) begin
            rst_st       <= fi_pkg::FI_BUS_RESP;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_mux;
            s_axi_rresp  <= known(s_axi_araddr) ? `FI_RESP_OK : `FI_RESP_ERR;
          end
        end
        fi_pkg::FI_BUS_RESP: begin
          if (s_axi_rready) begin
            rst_st        <= fi_pkg::FI_BUS_IDLE;
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
          end
        end
        default: begin
          rst_st        <= fi_pkg::FI_BUS_IDLE;
          s_axi_rvalid  <= 1'b0;
          s_axi_arready <= 1'b0;
        end
      endcase
    end
  end

  // Scheduler

  fi_sched #(
    .SEC_CYC   (SEC_CYC),
    .SEC10_CYC (SEC10_CYC)
  ) u_sched (
    .clk   (clk),
    .rst   (rst),
    .mode  (cfg.mode),
    .exp_n (exp_n),
    .group (group),
    .alt_n (alt_n),
    .trig  (trig),
    .blk   (in_valid),
    .frm   (in_valid && in_beat.sof),
    .used  (hit),
    .pend  (pend),
    .armed (armed)
  );

  // Corruption of the current beat

  assign lane_ok = lane_sel[in_beat.lane];

  always_comb begin
    nb   = in_beat;
    hit  = 1'b0;
    drop = 1'b0;
    er   = 1'b0;
    if (in_valid && armed && cfg.mode != fi_pkg::FI_OFF && !cfg.alarm) begin
      case (cfg.dest)
        fi_pkg::FI_D_IFG: if (in_beat.kind == fi_pkg::FI_K_IDLE) begin
          drop = 1'b1;
          hit  = 1'b1;
        end
        fi_pkg::FI_D_FCS: if (in_beat.kind == fi_pkg::FI_K_FCS) begin
          nb.data[31:0] = ~in_beat.data[31:0];
          hit           = 1'b1;
        end
        fi_pkg::FI_D_PRE: if (in_beat.kind == fi_pkg::FI_K_PRE
                              && cfg.speed <= fi_pkg::FI_10G) begin
          nb.data[15:8] = ~in_beat.data[15:8];
          hit           = 1'b1;
        end
        fi_pkg::FI_D_IPCS: if (in_beat.kind == fi_pkg::FI_K_IPCS) begin
          nb.data[15:0] = ~in_beat.data[15:0];
          hit           = 1'b1;
        end
        fi_pkg::FI_D_FRAG: if (in_beat.kind == fi_pkg::FI_K_IPFLG) begin
          nb.data[13] = 1'b1;
          hit         = 1'b1;
        end
        fi_pkg::FI_D_L4CS: if (in_beat.kind == fi_pkg::FI_K_L4CS) begin
          nb.data[15:0] = ~in_beat.data[15:0];
          hit           = 1'b1;
        end
        fi_pkg::FI_D_PAT: if (in_beat.kind == fi_pkg::FI_K_PAT) begin
          nb.data[0] = ~in_beat.data[0];
          hit        = 1'b1;
        end
        fi_pkg::FI_D_SEQ: if (in_beat.kind == fi_pkg::FI_K_SEQ) begin
          nb.data[0] = ~in_beat.data[0];
          hit        = 1'b1;
        end
        fi_pkg::FI_D_CV: if (in_beat.kind == fi_pkg::FI_K_DATA) begin
          if (cfg.speed == fi_pkg::FI_10G) begin
            nb.sync = 2'b00;
            hit     = 1'b1;
          end else if (cfg.speed == fi_pkg::FI_1G) begin
            er  = 1'b1;
            hit = 1'b1;
          end
        end
        fi_pkg::FI_D_FEC: if (in_beat.kind == fi_pkg::FI_K_FEC && cfg.fec
                              && cfg.speed >= fi_pkg::FI_25G) begin
          nb.data[9:0] = ~in_beat.data[9:0];
          hit          = 1'b1;
        end
        fi_pkg::FI_D_BTYPE: if (in_beat.kind == fi_pkg::FI_K_CTRL && lane_ok) begin
          nb.data[7:0] = 8'h00;
          hit          = 1'b1;
        end
        fi_pkg::FI_D_SYNC: if (in_beat.kind == fi_pkg::FI_K_DATA && lane_ok) begin
          nb.sync = 2'b11;
          hit     = 1'b1;
        end
        fi_pkg::FI_D_AM: if (in_beat.kind == fi_pkg::FI_K_AM && lane_ok) begin
          nb.data[23:0] = ~in_beat.data[23:0];
          hit           = 1'b1;
        end
        fi_pkg::FI_D_BIP: if (in_beat.kind == fi_pkg::FI_K_AM && lane_ok) begin
          nb.data[31:24] = ~in_beat.data[31:24];
          hit            = 1'b1;
        end
        default: ;
      endcase
    end
  end

  // Output stage

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      out_beat  <= '0;
      out_valid <= 1'b0;
      tx_er     <= 1'b0;
    end else begin
      out_beat  <= nb;
      out_valid <= in_valid && !drop;
      tx_er     <= er;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) alarm_active <= 1'b0;
    else alarm_active <= cfg.alarm;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) ins_cnt <= 32'h0;
    else if (hit) ins_cnt <= ins_cnt + 32'h1;
  end

  // Checks

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  chk_off_passthru: assert property (
    (cfg.mode == fi_pkg::FI_OFF && in_valid) |=> out_valid && out_beat == $past(in_beat)
  ) else $error("traffic altered in off mode");

  chk_manual_load: assert property (
    (cfg.mode == fi_pkg::FI_MANUAL && trig && pend == 17'h0) |=> pend == {1'b0, $past(group)}
  ) else $error("manual trigger did not load one group");

  chk_manual_stop: assert property (
    (cfg.mode == fi_pkg::FI_MANUAL && pend == 17'h0) |-> !hit
  ) else $error("error inserted with nothing pending");

  chk_ratio_trig: assert property (
    (cfg.mode == fi_pkg::FI_RATIO && trig && !in_valid) |=> pend == $past(pend)
  ) else $error("trigger changed ratio schedule");

  chk_alarm_hold: assert property (
    cfg.alarm [*2] |-> alarm_active && !hit
  ) else $error("alarm not held or error sent during alarm");

  chk_gap_short: assert property (
    (hit && cfg.dest == fi_pkg::FI_D_IFG) |=> !out_valid
  ) else $error("gap beat not removed");

  chk_fcs_bad: assert property (
    (hit && cfg.dest == fi_pkg::FI_D_FCS) |=> out_beat.data[31:0] != $past(in_beat.data[31:0])
  ) else $error("frame check value not corrupted");

  chk_pre_rate: assert property (
    (cfg.dest == fi_pkg::FI_D_PRE && cfg.speed > fi_pkg::FI_10G) |-> !hit
  ) else $error("preamble fault above 10G");

  chk_cv_txer: assert property (
    (hit && cfg.dest == fi_pkg::FI_D_CV && cfg.speed == fi_pkg::FI_1G) |=> tx_er
  ) else $error("coding violation did not raise tx_er");

  chk_fec_gate: assert property (
    (hit && cfg.dest == fi_pkg::FI_D_FEC) |-> cfg.fec && cfg.speed >= fi_pkg::FI_25G
  ) else $error("fec fault while fec off or wrong rate");

  chk_lane_mask: assert property (
    (hit && cfg.dest >= fi_pkg::FI_D_BTYPE) |-> lane_sel[in_beat.lane]
  ) else $error("pcs fault in an unselected lane");

  chk_pend_drain: assert property (
    (hit && !trig && cfg.mode == fi_pkg::FI_BURST) |=> pend == $past(pend) - 17'h1
  ) else $error("burst count not consumed by one");

  cov_manual: cover property (cfg.mode == fi_pkg::FI_MANUAL && trig ##[1:50] hit);
  cov_ratio: cover property (cfg.mode == fi_pkg::FI_RATIO && hit);
  cov_pcs: cover property (cfg.dest == fi_pkg::FI_D_SYNC && hit);
  cov_alarm: cover property ($rose(alarm_active));

endmodule // fi_top
`default_nettype wire
